// *** bench/vitm_chk_monitor.sv ***
// checker for the irq timestamp monitor command port
// assumes a bind to the top module, one clock domain
`default_nettype none

module vitm_chk (
   input  wire logic                SYS_CLK_I,
   input  wire logic                RESET_I,
   input  wire logic                CMD_VALID_I,
   input  wire vitm_pkg::vitm_cmd_t CMD_I,
   input  wire logic                CMD_READY_O,
   input  wire logic                RSP_VALID_O,
   input  wire vitm_pkg::vitm_rsp_t RSP_O,
   input  wire logic [6:0]          IRQ_LATCHED_O,
   input  wire logic [15:0]         MASK_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);
   // taken commands by kind
   wire        tk = CMD_VALID_I && CMD_READY_O;
   wire        wr = tk && CMD_I.op == vitm_pkg::OP_MASK_WRITE;
   wire        ok = CMD_I.arg <= vitm_pkg::MASK_MAX;
   wire        st = tk && CMD_I.op == vitm_pkg::OP_MON_START;
   wire        qy = tk && CMD_I.op == vitm_pkg::OP_TIME_QUERY;
   wire [15:0] wa = CMD_I.arg[15:0];
   sequence s_wr_ok;
      wr && ok;
   endsequence
   sequence s_wr_bad;
      wr && !ok;
   endsequence
   AST_RSP_ONE: assert property (tk |=> RSP_VALID_O)
      else $error("no answer after a command");
   AST_RSP_NONE: assert property (!tk |=> !RSP_VALID_O)
      else $error("answer without a command");
   AST_MASK_WR: assert property (s_wr_ok |=>
      RSP_O.mask == $past(wa) ##1 MASK_O == $past(wa, 2))
      else $error("mask write not stored");
   AST_MASK_BAD: assert property (s_wr_bad |=>
      RSP_O.err_code == vitm_pkg::ERR_DATA_RANGE ##1 $stable(MASK_O))
      else $error("bad mask value not refused");
   AST_PRESET: assert property (
      tk && CMD_I.op == vitm_pkg::OP_PRESET |-> ##2
      MASK_O == vitm_pkg::MASK_PRESET)
      else $error("preset did not load mask");
   AST_QRY_BAD: assert property (
      qy && (CMD_I.arg == 0 || CMD_I.arg > 7) |=>
      RSP_O.err_code == vitm_pkg::ERR_DATA_RANGE &&
      RSP_O.stamp == vitm_pkg::TIME_ZERO)
      else $error("bad line selector not refused");
   AST_TIME_RANGE: assert property (
      RSP_VALID_O && RSP_O.op == vitm_pkg::OP_TIME_QUERY |->
      RSP_O.stamp.seconds <= vitm_pkg::SEC_LAST &&
      RSP_O.stamp.minutes <= vitm_pkg::MIN_LAST)
      else $error("time field out of range");
   AST_LATCH_HOLD: assert property (
      |($past(IRQ_LATCHED_O) & ~IRQ_LATCHED_O) |->
      $past(st) || $past(st, 2) || $past(st, 3))
      else $error("latched line cleared without start");
endmodule : vitm_chk

bind vitm_irq_timestamp_monitor vitm_chk i_chk (
   .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
   .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
   .CMD_READY_O(CMD_READY_O), .RSP_VALID_O(RSP_VALID_O),
   .RSP_O(RSP_O), .IRQ_LATCHED_O(IRQ_LATCHED_O), .MASK_O(MASK_O));

`default_nettype wire

// *** bench/vitm_irq_src.sv ***
// backplane modules pulling irq lines low on request
// assumes one fire pulse per assertion; lines have pull-ups
`default_nettype none

module vitm_irq_src #(
   parameter int LOW_CYC = 6
) (
   input  wire logic       clk_i,
   input  wire logic [6:0] fire_i,
   output var  logic [6:0] irq_n_o
);
   int cnt [7];
   // hold each line low a while, then release it
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 7; i++) begin
         if (fire_i[i]) cnt[i] <= LOW_CYC;
         else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      end
   end
   // released line goes to the pull-up level
   always_comb begin
      for (int i = 0; i < 7; i++) irq_n_o[i] = !(cnt[i] > 0);
   end
endmodule : vitm_irq_src

`default_nettype wire

// *** bench/vitm_irq_timestamp_monitor_tb_top.sv ***
// bench for the irq timestamp monitor
// assumes the partner drives the irq pins from fire pulses
`default_nettype none

module vitm_irq_timestamp_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 0, rst = 1, flag = 0, valid = 0;
   logic                rdy, rv;
   logic [15:0]         nv = 16'h1234, msk;
   logic [6:0]          fire = '0, irq_n, lat, ev;
   logic [27:0]         s1;
   vitm_pkg::vitm_cmd_t c = '0;
   vitm_pkg::vitm_rsp_t r, ro;
   int                  n_mismatch = 0, checks_done = 0;
   int                  cyc = 0, rel = 0, t1 = 0, e = 0;
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   vitm_irq_src i_src (.clk_i(clk), .fire_i(fire), .irq_n_o(irq_n));
   vitm_irq_timestamp_monitor #(.TICKS_PER_SEC(10)) i_dut (
      .SYS_CLK_I(clk), .RESET_I(rst), .IRQ_N_I(irq_n),
      .POWER_ON_STATUS_CLEAR_FLAG_I(flag), .NV_MASK_I(nv),
      .CMD_VALID_I(valid), .CMD_I(c), .CMD_READY_O(rdy),
      .RSP_VALID_O(rv), .RSP_O(ro), .IRQ_LATCHED_O(lat),
      .IRQ_EVENT_O(ev), .MASK_O(msk));
   task automatic chk(input logic [31:0] s, x);
      checks_done++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD %0t seen %0h want %0h", $time, s, x);
      end
   endtask : chk
   // one command, answer taken one cycle after it
   task automatic cmd(input vitm_pkg::vitm_op_t op, input logic [31:0] a);
      @(posedge clk);
      #1 valid = 1;
      c = '{op, a};
      @(posedge clk);
      #1 valid = 0;
      r = ro;
      chk(rv, 1);
   endtask : cmd
   task automatic rst_go(input logic f);
      rst = 1;
      flag = f;
      repeat (5) @(posedge clk);
      #1 rst = 0;
      rel = cyc;
      repeat (2) @(posedge clk);
   endtask : rst_go
   task automatic pulse(input logic [6:0] m);
      @(posedge clk);
      #1 fire = m;
      @(posedge clk);
      #1 fire = '0;
      repeat (10) @(posedge clk);
   endtask : pulse
   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // cycle count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         test_done;
      end
   end
   // main sequence
   initial begin
      rst_go(0);
      cmd(vitm_pkg::OP_MASK_READ, '0);
      chk(r.mask, 16'h1234);
      cmd(vitm_pkg::OP_TIME_QUERY, 3);
      chk(r.stamp, '0);
      cmd(vitm_pkg::OP_MASK_WRITE, 32'h0000FFFF);
      chk(r.err_code, '0);
      cmd(vitm_pkg::OP_MASK_WRITE, 32'h00010000);
      chk(r.err_code, 16'hFF22);
      cmd(vitm_pkg::OP_MASK_READ, '0);
      chk(r.mask, 16'hFFFF);
      cmd(vitm_pkg::OP_MASK_WRITE, 32'h00008001);
      cmd(vitm_pkg::OP_NOP, '0);
      chk(r.mask, 16'h8001);
      repeat (40) @(posedge clk);
      t1 = cyc - rel;
      pulse(7'h03);
      chk(lat, 7'h03);
      chk(ev, 7'h01);
      cmd(vitm_pkg::OP_COND_READ, '0);
      chk(r.cond, 7'h03);
      cmd(vitm_pkg::OP_TIME_QUERY, 1);
      s1 = r.stamp;
      e = t1 / 10;
      chk(r.stamp.seconds inside {[e - 1 : e + 2]}, 1);
      chk(r.stamp.hours, '0);
      repeat (30) @(posedge clk);
      pulse(7'h01);
      cmd(vitm_pkg::OP_TIME_QUERY, 1);
      chk(r.stamp, s1);
      cmd(vitm_pkg::OP_TIME_QUERY, 2);
      chk(r.stamp, s1);
      for (int i = 3; i <= 7; i++) begin
         cmd(vitm_pkg::OP_TIME_QUERY, i);
         chk(r.stamp, '0);
      end
      cmd(vitm_pkg::OP_TIME_QUERY, 0);
      chk(r.err_code, 16'hFF22);
      cmd(vitm_pkg::OP_TIME_QUERY, 8);
      chk(r.err_code, 16'hFF22);
      cmd(vitm_pkg::OP_MON_START, '0);
      cmd(vitm_pkg::OP_TIME_QUERY, 1);
      chk(r.stamp, '0);
      repeat (5) @(posedge clk);
      chk(lat, '0);
      pulse(7'h04);
      cmd(vitm_pkg::OP_TIME_QUERY, 3);
      chk(r.stamp != '0, 1);
      cmd(vitm_pkg::OP_PRESET, '0);
      cmd(vitm_pkg::OP_MASK_READ, '0);
      chk(r.mask, 16'h7FFF);
      rst_go(1);
      cmd(vitm_pkg::OP_MASK_READ, '0);
      chk(r.mask, 16'h7FFF);
      cmd(vitm_pkg::OP_TIME_QUERY, 3);
      chk(r.stamp, '0);
      test_done;
   end
endmodule : vitm_irq_timestamp_monitor_tb_top

`default_nettype wire

// *** rtl/vitm_elapsed_timer.sv ***
// elapsed time since power-on as hours, minutes, seconds
// assumes reset is the power-on reset; never cleared otherwise
`default_nettype none

module vitm_elapsed_timer #(
   parameter int unsigned TICKS = vitm_pkg::TICKS_PER_SEC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   output var  vitm_pkg::vitm_time_t now_o
);

   logic [31:0] tick_q;
   logic        sec_stb;

   // wrapping increment shared by the seconds and minutes fields
   function automatic logic [5:0] wrap_inc(input logic [5:0] v,
                                           input logic [5:0] last);
      if (v == last) begin
         wrap_inc = 6'h00;
      end else begin
         wrap_inc = v + 6'h01;
      end
   endfunction : wrap_inc

   assign sec_stb = (tick_q == TICKS[31:0] - 32'h00000001);

   // sub-second prescaler
   always_ff @(posedge clk_i) begin
      if (rst_i || sec_stb) begin
         tick_q <= 32'h00000000;
      end else begin
         tick_q <= tick_q + 32'h00000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         now_o <= vitm_pkg::TIME_ZERO;
      end else if (sec_stb) begin
         now_o.seconds <= wrap_inc(now_o.seconds, vitm_pkg::SEC_LAST);
         if (now_o.seconds == vitm_pkg::SEC_LAST) begin
            now_o.minutes <= wrap_inc(now_o.minutes, vitm_pkg::MIN_LAST);
            if (now_o.minutes == vitm_pkg::MIN_LAST) begin
               now_o.hours <= now_o.hours + 16'h0001;
            end
         end
      end
   end

endmodule : vitm_elapsed_timer

`default_nettype wire

// *** rtl/vitm_irq_timestamp_monitor.sv ***
// first-assertion timestamp capture for the seven bus irq lines
// assumes irq pins are asynchronous and active low; command port,
// clear flag and nonvolatile mask copy come from same-clock logic
`default_nettype none

module vitm_irq_timestamp_monitor #(
   parameter int unsigned TICKS_PER_SEC = vitm_pkg::TICKS_PER_SEC
) (
   input  wire logic                 SYS_CLK_I,
   input  wire logic                 RESET_I,
   // backplane interrupt request pins, bit 0 is IRQ1
   input  wire logic [6:0]           IRQ_N_I,
   // strap-like inputs sampled once after reset
   input  wire logic                 POWER_ON_STATUS_CLEAR_FLAG_I,
   input  wire logic [15:0]          NV_MASK_I,
   // command request and answer
   input  wire logic                 CMD_VALID_I,
   input  wire vitm_pkg::vitm_cmd_t  CMD_I,
   output var  logic                 CMD_READY_O,
   output var  logic                 RSP_VALID_O,
   output var  vitm_pkg::vitm_rsp_t  RSP_O,
   // live view of latched lines and enabled events
   output var  logic [6:0]           IRQ_LATCHED_O,
   output var  logic [6:0]           IRQ_EVENT_O,
   output var  logic [15:0]          MASK_O
);

   typedef enum {
      ST_INIT,
      ST_RUN
   } vitm_state_t;

   vitm_state_t state_q;

   logic [6:0]           irq_meta_q;
   logic [6:0]           irq_sync_q;
   logic [6:0]           irq_prev_q;
   logic [6:0]           irq_level;
   logic [6:0]           irq_rise;

   logic [6:0]           armed_q;
   logic [6:0]           cond_q;
   vitm_pkg::vitm_time_t cap_q [vitm_pkg::NUM_IRQ];
   logic [15:0]          mask_q;
   vitm_pkg::vitm_time_t now;

   logic                 cmd_take;
   logic                 do_start;
   logic                 do_mask_write;
   logic                 do_preset;
   logic                 mask_arg_ok;
   logic                 sel_ok;
   logic [2:0]           sel_idx;

   // elapsed time source
   vitm_elapsed_timer #(
      .TICKS (TICKS_PER_SEC)
   ) u_timer (
      .clk_i (SYS_CLK_I),
      .rst_i (RESET_I),
      .now_o (now)
   );

   // two-flop synchroniser on the irq pins
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         irq_meta_q <= 7'h7F;
         irq_sync_q <= 7'h7F;
      end else begin
         irq_meta_q <= IRQ_N_I;
         irq_sync_q <= irq_meta_q;
      end
   end

   // previous asserted level for edge finding
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         irq_prev_q <= 7'h00;
      end else begin
         irq_prev_q <= irq_level;
      end
   end

   assign irq_level = ~irq_sync_q;
   assign irq_rise  = irq_level & ~irq_prev_q;

   // command decode
   assign cmd_take      = CMD_VALID_I && (state_q == ST_RUN);
   assign do_start      = cmd_take && (CMD_I.op == vitm_pkg::OP_MON_START);
   assign do_preset     = cmd_take && (CMD_I.op == vitm_pkg::OP_PRESET);
   assign do_mask_write = cmd_take && (CMD_I.op == vitm_pkg::OP_MASK_WRITE);
   assign mask_arg_ok   = (CMD_I.arg <= vitm_pkg::MASK_MAX);

   // line selector check and zero-based index
   assign sel_ok  = (CMD_I.arg[31:3] == 29'h00000000) &&
                    (CMD_I.arg[2:0] >= vitm_pkg::IRQ_SEL_FIRST) &&
                    (CMD_I.arg[2:0] <= vitm_pkg::IRQ_SEL_LAST);
   assign sel_idx = CMD_I.arg[2:0] - vitm_pkg::IRQ_SEL_FIRST;

   // init then run; the init cycle takes the power-on mask choice
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         state_q <= ST_INIT;
      end else begin
         case (state_q)
            ST_INIT: begin
               state_q <= ST_RUN;
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_INIT;
            end
         endcase
      end
   end

   // enable mask register
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         mask_q <= vitm_pkg::MASK_RESET;
      end else if (state_q == ST_INIT) begin
         if (POWER_ON_STATUS_CLEAR_FLAG_I) begin
            mask_q <= vitm_pkg::MASK_PRESET;
         end else begin
            mask_q <= NV_MASK_I;
         end
      end else if (do_preset) begin
         mask_q <= vitm_pkg::MASK_PRESET;
      end else if (do_mask_write && mask_arg_ok) begin
         // store full value, unused bits kept
         mask_q <= CMD_I.arg[15:0];
      end
   end

   // armed flags: cleared by capture, rearmed by start or power-on
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         armed_q <= 7'h7F;
      end else begin
         for (int i = 0; i < vitm_pkg::NUM_IRQ; i++) begin
            if (irq_rise[i] && armed_q[i]) begin
               armed_q[i] <= 1'b0;
            end else if (do_start) begin
               armed_q[i] <= 1'b1;
            end
         end
      end
   end

   // capture registers, one per line
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         for (int i = 0; i < vitm_pkg::NUM_IRQ; i++) begin
            cap_q[i] <= vitm_pkg::TIME_ZERO;
         end
      end else begin
         for (int i = 0; i < vitm_pkg::NUM_IRQ; i++) begin
            // only while armed, copy the clock
            if (irq_rise[i] && armed_q[i]) begin
               cap_q[i] <= now;
            end else if (do_start) begin
               cap_q[i] <= vitm_pkg::TIME_ZERO;
            end
         end
      end
   end

   // latched line state
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         cond_q <= 7'h00;
      end else begin
         for (int i = 0; i < vitm_pkg::NUM_IRQ; i++) begin
            // latch, cleared by start unless set now
            if (irq_level[i]) begin
               cond_q[i] <= 1'b1;
            end else if (do_start) begin
               cond_q[i] <= 1'b0;
            end
         end
      end
   end

   // live outputs, registered
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         IRQ_LATCHED_O <= 7'h00;
         IRQ_EVENT_O   <= 7'h00;
         MASK_O        <= vitm_pkg::MASK_RESET;
      end else begin
         IRQ_LATCHED_O <= cond_q;
         // only low seven mask bits gate events
         IRQ_EVENT_O   <= cond_q & mask_q[6:0];
         MASK_O        <= mask_q;
      end
   end

   // ready once the power-on mask is settled
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         CMD_READY_O <= 1'b0;
      end else begin
         CMD_READY_O <= 1'b1;
      end
   end

   // answer path, one cycle after the command is taken
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         RSP_VALID_O <= 1'b0;
         RSP_O       <= '0;
      end else begin
         RSP_VALID_O    <= cmd_take;
         RSP_O.op       <= CMD_I.op;
         RSP_O.stamp    <= vitm_pkg::TIME_ZERO;
         RSP_O.mask     <= 16'h0000;
         RSP_O.cond     <= 7'h00;
         RSP_O.err_code <= vitm_pkg::ERR_NONE;
         if (cmd_take) begin
            case (CMD_I.op)
               vitm_pkg::OP_TIME_QUERY: begin
                  // selected line time, zero if none
                  if (sel_ok) begin
                     RSP_O.stamp <= cap_q[sel_idx];
                  end else begin
                     RSP_O.err_code <= vitm_pkg::ERR_DATA_RANGE;
                  end
               end
               vitm_pkg::OP_MASK_WRITE: begin
                  // out of range leaves mask, reports error
                  if (!mask_arg_ok) begin
                     RSP_O.err_code <= vitm_pkg::ERR_DATA_RANGE;
                  end
                  RSP_O.mask <= mask_arg_ok ? CMD_I.arg[15:0] : mask_q;
               end
               vitm_pkg::OP_MASK_READ: begin
                  RSP_O.mask <= mask_q;
               end
               vitm_pkg::OP_PRESET: begin
                  RSP_O.mask <= vitm_pkg::MASK_PRESET;
               end
               vitm_pkg::OP_COND_READ: begin
                  RSP_O.cond <= cond_q;
               end
               default: begin
                  RSP_O.mask <= mask_q;
               end
            endcase
         end
      end
   end

endmodule : vitm_irq_timestamp_monitor

`default_nettype wire

// *** rtl/vitm_pkg.sv ***
// constants, types and command codes for the irq timestamp monitor
// assumes a single 125 MHz clock and a command port driven by firmware
`default_nettype none

package vitm_pkg;

   // clock and elapsed time
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SECOND_NS     = 1_000_000_000;
   localparam int unsigned TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [5:0]  SEC_LAST      = 6'h3B;
   localparam logic [5:0]  MIN_LAST      = 6'h3B;

   // interrupt lines
   localparam int unsigned NUM_IRQ       = 7;
   localparam logic [2:0]  IRQ_SEL_FIRST = 3'h1;
   localparam logic [2:0]  IRQ_SEL_LAST  = 3'h7;

   // enable mask
   localparam int unsigned MASK_W        = 16;
   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] MASK_PRESET   = 16'h7FFF;
   localparam logic [31:0] MASK_MAX      = 32'h0000FFFF;

   // error codes, two's complement
   localparam logic [15:0] ERR_NONE       = 16'h0000;
   localparam logic [15:0] ERR_DATA_RANGE = 16'hFF22;

   // command codes
   typedef enum logic [2:0] {
      OP_NOP        = 3'h0,
      OP_TIME_QUERY = 3'h1,
      OP_MASK_WRITE = 3'h2,
      OP_MASK_READ  = 3'h3,
      OP_PRESET     = 3'h4,
      OP_MON_START  = 3'h5,
      OP_COND_READ  = 3'h6
   } vitm_op_t;

   typedef struct packed {
      logic [15:0] hours;
      logic [5:0]  minutes;
      logic [5:0]  seconds;
   } vitm_time_t;

   typedef struct packed {
      vitm_op_t    op;
      logic [31:0] arg;
   } vitm_cmd_t;

   typedef struct packed {
      vitm_op_t    op;
      vitm_time_t  stamp;
      logic [15:0] mask;
      logic [6:0]  cond;
      logic [15:0] err_code;
   } vitm_rsp_t;

   localparam vitm_time_t TIME_ZERO = '{16'h0000, 6'h00, 6'h00};

endpackage : vitm_pkg

`default_nettype wire
